// ### rtl/adcc_pkg.sv
// Constants, state types and field layout of the converter control block
// What this block does
// - Byte-wide registers return one byte per access
// - Pointer persists; reads repeat same register
// - Result, limit, hysteresis reads use two bytes
// - Extra acknowledged bytes keep returning register data
// - Shared pin is alert or busy output
// - Open-drain alert, polarity from D0, low default
// - Configuration D2 enables alert signalling
// - Acknowledge alert response only while asserting alert
// - Alert response uses arbitration, lowest address wins
// - Alert when result above upper or below lower
// - Configuration write with D1 set clears alert
// - Hysteresis return below/above limits clears alert
// - High-speed master code is never acknowledged
// - Repeated start then address, device acknowledges
// - High-speed mode ends at STOP
// - Address from three-state select pin, sampled once
// - Start pin rising edge begins power-up
// - Falling edge holds, converts, then shuts down
// - Short high time still converts, result invalid
// - D5/D4 pick channel; both alternate per pulse
// - Limit and hysteresis registers are twelve bits
package adcc_pkg;
  localparam logic [2:0] ADDR_MSB      = 3'h2;
  localparam logic [6:0] ARA_ADDR      = 7'h0c;
  localparam logic [4:0] HS_CODE       = 5'h01;
  localparam logic [3:0] PTR_RESULT    = 4'h0;
  localparam logic [3:0] PTR_ALERT     = 4'h1;
  localparam logic [3:0] PTR_CONFIG    = 4'h2;
  localparam logic [3:0] PTR_CYCLE     = 4'h3;
  localparam logic [3:0] PTR_LO1       = 4'h4;
  localparam logic [3:0] PTR_HI1       = 4'h5;
  localparam logic [3:0] PTR_HYS1      = 4'h6;
  localparam logic [3:0] PTR_LO2       = 4'h7;
  localparam logic [3:0] PTR_HI2       = 4'h8;
  localparam logic [3:0] PTR_HYS2      = 4'h9;
  localparam int         CFG_POL       = 0;
  localparam int         CFG_CLR       = 1;
  localparam int         CFG_EN        = 2;
  localparam int         CFG_BUSY      = 3;
  localparam int         CFG_CH1       = 4;
  localparam int         CFG_CH2       = 5;
  localparam int         RES_INV_BIT   = 14;
  localparam int         RES_CH_BIT    = 12;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] CYC_RESET     = 8'h00;
  localparam logic [11:0] HI_RESET     = 12'hfff;
  localparam logic [11:0] LO_RESET     = 12'h000;
  localparam logic [11:0] HYS_RESET    = 12'h000;
  localparam int         CLK_NS        = 20;
  localparam int         PWRUP_NS      = 1000;
  localparam int         CONV_NS       = 2000;
  localparam int         PWRUP_CYC     = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int         CONV_CYC      = CONV_NS / CLK_NS;

  typedef enum logic [2:0] {
    ADCC_IDLE     = 3'h0,
    ADCC_ADDR     = 3'h1,
    ADCC_ADDR_ACK = 3'h3,
    ADCC_WR       = 3'h2,
    ADCC_WR_ACK   = 3'h6,
    ADCC_RD       = 3'h7,
    ADCC_RD_ACK   = 3'h5
  } adcc_bus_e;

  typedef enum logic [1:0] {
    ADCC_SHUT  = 2'h0,
    ADCC_PWRUP = 2'h1,
    ADCC_CONV  = 2'h3
  } adcc_conv_e;
endpackage : adcc_pkg

// ### rtl/adcc_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module adcc_sync #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    // Reset to the pins' idle levels so no false edge follows reset
    if (!resetn) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : adcc_sync
`default_nettype wire

// ### rtl/adcc_convctl.sv
// Serial slave, alert and start-pin conversion control of a two-channel converter
`timescale 1ns/10ps
`default_nettype none
module adcc_convctl #(
  parameter logic [3:0] AS_LOW_CODE   = 4'h1, // Arbitrary value
  parameter logic [3:0] AS_HIGH_CODE  = 4'h2, // Arbitrary value
  parameter logic [3:0] AS_FLOAT_CODE = 4'h3  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        scl_pin,
  input  wire logic        sda_pin,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             alert_out,
  output logic             alert_oe,
  input  wire logic        conversion_start_n,
  input  wire logic        address_select_pin,
  input  wire logic        address_select_mid,
  input  wire logic [11:0] adc_code,
  output logic             adc_power_up,
  output logic             track_hold,
  output logic             conv_channel,
  output logic             result_invalid,
  output logic             hs_mode,
  output logic [3:0]       pointer_command_bits
);
  logic [4:0]        pins_s;
  logic              scl_s, sda_s, cs_s, as_hi_s, as_mid_s;
  logic              scl_d_reg, sda_d_reg, cs_d_reg;
  logic              scl_rise, scl_fall, start_ev, stop_ev, cs_rise, cs_fall;
  adcc_pkg::adcc_bus_e  state_reg;
  adcc_pkg::adcc_conv_e cv_state_reg;
  logic [3:0]        bit_cnt_reg;
  logic [7:0]        shift_reg;
  logic              sda_oe_reg, ara_reg, more_reg, rd_hi_reg;
  logic [15:0]       tx_word_reg;
  logic [7:0]        tx_byte;
  logic              tx_bit;
  logic [3:0]        ptr_reg, cmd_reg;
  logic              wr_first_reg, wr_pend_reg;
  logic [3:0]        wr_hold_reg;
  logic [7:0]        cfg_reg, cyc_reg;
  logic [11:0]       lim_hi_reg [2];
  logic [11:0]       lim_lo_reg [2];
  logic [11:0]       hyst_reg   [2];
  logic [15:0]       result_reg;
  logic [1:0]        hi_flag_reg, lo_flag_reg;
  logic [1:0]        hi_set, lo_set, hi_clr, lo_clr;
  logic [15:0]       rd_value;
  logic [3:0]        as_code_reg;
  logic              as_done_reg;
  logic [6:0]        dev_addr;
  logic              addr_end, dev_hit, ara_hit, hs_hit, wr_byte_done, cfg_clear;
  logic [7:0]        cv_cnt_reg;
  logic              seq_reg, conv_done, alert_asserted, pin_active;

  // Wide registers take two bytes per value
  function automatic logic is_wide(input logic [3:0] ptr);
    is_wide = (ptr == adcc_pkg::PTR_RESULT) || (ptr >= adcc_pkg::PTR_LO1 && ptr <= adcc_pkg::PTR_HYS2);
  endfunction : is_wide

  // Bus lines idle high, start and select pins idle low
  adcc_sync #(.W(5), .RESET_VAL(5'h18)) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({scl_pin, sda_pin, conversion_start_n, address_select_pin, address_select_mid}),
    .sync_out (pins_s)
  );
  assign {scl_s, sda_s, cs_s, as_hi_s, as_mid_s} = pins_s;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      cs_d_reg  <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      cs_d_reg  <= cs_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign cs_rise  = cs_s & ~cs_d_reg;
  assign cs_fall  = ~cs_s & cs_d_reg;

  // Address decision happens on the falling clock after the eighth bit
  assign dev_addr = {adcc_pkg::ADDR_MSB, as_code_reg};
  assign addr_end = (state_reg == adcc_pkg::ADCC_ADDR) && scl_fall && (bit_cnt_reg == 4'h8);
  assign dev_hit  = (shift_reg[7:1] == dev_addr);
  assign ara_hit  = (shift_reg[7:1] == adcc_pkg::ARA_ADDR) && shift_reg[0] && alert_asserted;
  assign hs_hit   = (shift_reg[7:3] == adcc_pkg::HS_CODE);
  assign wr_byte_done = (state_reg == adcc_pkg::ADCC_WR) && scl_fall && (bit_cnt_reg == 4'h8);

  assign tx_byte = ara_reg ? {dev_addr, 1'b0} :
                   (is_wide(ptr_reg) && rd_hi_reg) ? tx_word_reg[15:8] : tx_word_reg[7:0];
  assign tx_bit  = tx_byte[~bit_cnt_reg[2:0]];

  // Bus state machine; SDA is only ever pulled low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg   <= adcc_pkg::ADCC_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      sda_oe_reg  <= 1'b0;
      more_reg    <= 1'b0;
    end else if (stop_ev) begin
      state_reg  <= adcc_pkg::ADCC_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_ev) begin
      state_reg   <= adcc_pkg::ADCC_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg  <= 1'b0;
    end else begin
      case (state_reg)
        adcc_pkg::ADCC_ADDR, adcc_pkg::ADCC_WR: begin
          if (scl_rise && bit_cnt_reg != 4'h8) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (addr_end) begin
            if ((dev_hit || ara_hit) && !hs_hit) begin
              state_reg  <= adcc_pkg::ADCC_ADDR_ACK;
              sda_oe_reg <= 1'b1;
            end else begin
              state_reg <= adcc_pkg::ADCC_IDLE;
            end
          end else if (wr_byte_done) begin
            state_reg  <= adcc_pkg::ADCC_WR_ACK;
            sda_oe_reg <= 1'b1;
          end
        end
        adcc_pkg::ADCC_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (shift_reg[0]) begin
              state_reg  <= adcc_pkg::ADCC_RD;
              sda_oe_reg <= ~tx_bit;
            end else begin
              state_reg  <= adcc_pkg::ADCC_WR;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        adcc_pkg::ADCC_WR_ACK: begin
          if (scl_fall) begin
            state_reg   <= adcc_pkg::ADCC_WR;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg  <= 1'b0;
          end
        end
        adcc_pkg::ADCC_RD: begin
          if (scl_rise) begin
            // Released a one but the line is low: another slave won
            if (!sda_oe_reg && !sda_s) begin
              state_reg <= adcc_pkg::ADCC_IDLE;
            end
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              state_reg  <= adcc_pkg::ADCC_RD_ACK;
              sda_oe_reg <= 1'b0;
            end else begin
              sda_oe_reg <= ~tx_bit;
            end
          end
        end
        adcc_pkg::ADCC_RD_ACK: begin
          if (scl_rise) begin
            more_reg <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (more_reg) begin
              state_reg  <= adcc_pkg::ADCC_RD;
              sda_oe_reg <= ~tx_bit;
            end else begin
              state_reg <= adcc_pkg::ADCC_IDLE;
            end
          end
        end
        default: begin
          state_reg  <= adcc_pkg::ADCC_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_reg;

  // Read data: word latched per value so both bytes come from one sample
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_word_reg <= 16'h0000;
      rd_hi_reg   <= 1'b1;
      ara_reg     <= 1'b0;
    end else if (addr_end) begin
      tx_word_reg <= rd_value;
      rd_hi_reg   <= 1'b1;
      ara_reg     <= ara_hit && !dev_hit;
    end else if (state_reg == adcc_pkg::ADCC_RD_ACK && scl_rise && !sda_s) begin
      if (is_wide(ptr_reg) && rd_hi_reg) begin
        rd_hi_reg <= 1'b0;
      end else begin
        tx_word_reg <= rd_value;
        rd_hi_reg   <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_value = 16'h0000;
    case (ptr_reg)
      adcc_pkg::PTR_RESULT: rd_value = result_reg;
      adcc_pkg::PTR_ALERT:  rd_value = {12'h000, hi_flag_reg[1], lo_flag_reg[1], hi_flag_reg[0], lo_flag_reg[0]};
      adcc_pkg::PTR_CONFIG: rd_value = {8'h00, cfg_reg};
      adcc_pkg::PTR_CYCLE:  rd_value = {8'h00, cyc_reg};
      adcc_pkg::PTR_LO1:    rd_value = {4'h0, lim_lo_reg[0]};
      adcc_pkg::PTR_HI1:    rd_value = {4'h0, lim_hi_reg[0]};
      adcc_pkg::PTR_HYS1:   rd_value = {4'h0, hyst_reg[0]};
      adcc_pkg::PTR_LO2:    rd_value = {4'h0, lim_lo_reg[1]};
      adcc_pkg::PTR_HI2:    rd_value = {4'h0, lim_hi_reg[1]};
      adcc_pkg::PTR_HYS2:   rd_value = {4'h0, hyst_reg[1]};
      default:              rd_value = 16'h0000;
    endcase
  end

  // Writes: first byte loads the pointer, later bytes fill the register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ptr_reg      <= adcc_pkg::PTR_RESULT;
      cmd_reg      <= 4'h0;
      wr_first_reg <= 1'b1;
      wr_pend_reg  <= 1'b0;
      wr_hold_reg  <= 4'h0;
      cfg_reg      <= adcc_pkg::CFG_RESET;
      cyc_reg      <= adcc_pkg::CYC_RESET;
      lim_hi_reg   <= '{adcc_pkg::HI_RESET, adcc_pkg::HI_RESET};
      lim_lo_reg   <= '{adcc_pkg::LO_RESET, adcc_pkg::LO_RESET};
      hyst_reg     <= '{adcc_pkg::HYS_RESET, adcc_pkg::HYS_RESET};
    end else if (addr_end) begin
      wr_first_reg <= 1'b1;
      wr_pend_reg  <= 1'b0;
    end else if (wr_byte_done) begin
      if (wr_first_reg) begin
        ptr_reg      <= shift_reg[3:0];
        cmd_reg      <= shift_reg[7:4];
        wr_first_reg <= 1'b0;
      end else if (is_wide(ptr_reg) && !wr_pend_reg) begin
        wr_hold_reg <= shift_reg[3:0];
        wr_pend_reg <= 1'b1;
      end else begin
        wr_first_reg <= 1'b1;
        wr_pend_reg  <= 1'b0;
        case (ptr_reg)
          adcc_pkg::PTR_CONFIG: cfg_reg <= shift_reg;
          adcc_pkg::PTR_CYCLE:  cyc_reg <= shift_reg;
          adcc_pkg::PTR_LO1:    lim_lo_reg[0] <= {wr_hold_reg, shift_reg};
          adcc_pkg::PTR_HI1:    lim_hi_reg[0] <= {wr_hold_reg, shift_reg};
          adcc_pkg::PTR_HYS1:   hyst_reg[0]   <= {wr_hold_reg, shift_reg};
          adcc_pkg::PTR_LO2:    lim_lo_reg[1] <= {wr_hold_reg, shift_reg};
          adcc_pkg::PTR_HI2:    lim_hi_reg[1] <= {wr_hold_reg, shift_reg};
          adcc_pkg::PTR_HYS2:   hyst_reg[1]   <= {wr_hold_reg, shift_reg};
          default: ;
        endcase
      end
    end
  end

  assign pointer_command_bits = cmd_reg;
  assign cfg_clear = wr_byte_done && !wr_first_reg && (ptr_reg == adcc_pkg::PTR_CONFIG)
                     && shift_reg[adcc_pkg::CFG_CLR];

  // Address select is judged once, mid first address byte, to let a floating pin settle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      as_code_reg <= AS_LOW_CODE;
      as_done_reg <= 1'b0;
    end else if (state_reg == adcc_pkg::ADCC_ADDR && scl_rise && bit_cnt_reg == 4'h3 && !as_done_reg) begin
      as_done_reg <= 1'b1;
      as_code_reg <= as_mid_s ? AS_FLOAT_CODE : (as_hi_s ? AS_HIGH_CODE : AS_LOW_CODE);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hs_mode <= 1'b0;
    end else if (stop_ev) begin
      hs_mode <= 1'b0;
    end else if (addr_end && hs_hit) begin
      hs_mode <= 1'b1;
    end
  end

  // Start pin sequencing: power-up on rise, hold and convert on fall
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cv_state_reg   <= adcc_pkg::ADCC_SHUT;
      cv_cnt_reg     <= 8'h00;
      result_invalid <= 1'b0;
    end else begin
      case (cv_state_reg)
        adcc_pkg::ADCC_SHUT: begin
          cv_cnt_reg <= 8'h00;
          if (cs_rise) begin
            cv_state_reg <= adcc_pkg::ADCC_PWRUP;
          end else if (cs_fall) begin
            cv_state_reg   <= adcc_pkg::ADCC_CONV;
            result_invalid <= 1'b1;
          end
        end
        adcc_pkg::ADCC_PWRUP: begin
          if (cs_fall) begin
            cv_state_reg   <= adcc_pkg::ADCC_CONV;
            result_invalid <= (cv_cnt_reg < 8'(adcc_pkg::PWRUP_CYC));
            cv_cnt_reg     <= 8'h00;
          end else if (cv_cnt_reg != 8'hff) begin
            cv_cnt_reg <= cv_cnt_reg + 8'h01;
          end
        end
        adcc_pkg::ADCC_CONV: begin
          cv_cnt_reg <= cv_cnt_reg + 8'h01;
          if (conv_done) begin
            cv_state_reg <= adcc_pkg::ADCC_SHUT;
            cv_cnt_reg   <= 8'h00;
          end
        end
        default: cv_state_reg <= adcc_pkg::ADCC_SHUT;
      endcase
    end
  end

  assign conv_done    = (cv_state_reg == adcc_pkg::ADCC_CONV) && (cv_cnt_reg == 8'(adcc_pkg::CONV_CYC - 1));
  assign adc_power_up = (cv_state_reg != adcc_pkg::ADCC_SHUT);
  assign track_hold   = (cv_state_reg == adcc_pkg::ADCC_CONV);

  // Channel choice; with both selected, each pulse moves to the other channel
  always_ff @(posedge clk) begin
    if (!resetn) begin
      seq_reg      <= 1'b0;
      conv_channel <= 1'b0;
    end else if (cs_fall && cv_state_reg != adcc_pkg::ADCC_CONV) begin
      conv_channel <= cfg_reg[adcc_pkg::CFG_CH2] & (~cfg_reg[adcc_pkg::CFG_CH1] | seq_reg);
      if (cfg_reg[adcc_pkg::CFG_CH2] && cfg_reg[adcc_pkg::CFG_CH1]) begin
        seq_reg <= ~seq_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_reg <= 16'h0000;
    end else if (conv_done) begin
      result_reg <= 16'h0000;
      result_reg[11:0] <= adc_code;
      result_reg[adcc_pkg::RES_CH_BIT] <= conv_channel;
      result_reg[adcc_pkg::RES_INV_BIT] <= result_invalid;
    end
  end

  // Set terms of the finishing conversion; clear terms of it and of a configuration clear
  always_comb begin
    hi_set = 2'h0;
    lo_set = 2'h0;
    hi_clr = {2{cfg_clear}};
    lo_clr = {2{cfg_clear}};
    if (conv_done) begin
      hi_set[conv_channel] = adc_code > lim_hi_reg[conv_channel];
      lo_set[conv_channel] = adc_code < lim_lo_reg[conv_channel];
      if ({1'b0, adc_code} + {1'b0, hyst_reg[conv_channel]} <= {1'b0, lim_hi_reg[conv_channel]}) begin
        hi_clr[conv_channel] = 1'b1;
      end
      if ({1'b0, adc_code} >= {1'b0, lim_lo_reg[conv_channel]} + {1'b0, hyst_reg[conv_channel]}) begin
        lo_clr[conv_channel] = 1'b1;
      end
    end
  end

  // Limit flags; a new violation wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hi_flag_reg <= 2'h0;
      lo_flag_reg <= 2'h0;
    end else begin
      hi_flag_reg <= (hi_flag_reg & ~hi_clr) | hi_set;
      lo_flag_reg <= (lo_flag_reg & ~lo_clr) | lo_set;
    end
  end

  assign alert_asserted = cfg_reg[adcc_pkg::CFG_EN] & (|hi_flag_reg | |lo_flag_reg);
  assign pin_active     = cfg_reg[adcc_pkg::CFG_BUSY] ? adc_power_up : alert_asserted;

  // Open drain: active-high polarity is shown by releasing the line
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= cfg_reg[adcc_pkg::CFG_POL] ? ~pin_active : pin_active;
    end
  end

  assign alert_out = 1'b0;
endmodule : adcc_convctl
`default_nettype wire

// ### testbench/adcc_convctl_properties.sv
// Port checks of the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcc_convctl_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic conversion_start_n,
  input wire logic adc_power_up,
  input wire logic track_hold,
  input wire logic conv_channel,
  input wire logic hs_mode
);
  logic [7:0] hold_cnt_reg;
  // Counts the length of each hold phase
  always_ff @(posedge clk) begin
    if (!resetn || !track_hold) hold_cnt_reg <= 8'h00;
    else hold_cnt_reg <= hold_cnt_reg + 8'h01;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  reset_quiet_a: assert property ($rose(resetn) |-> !sda_oe && !alert_oe && !hs_mode && !track_hold)
    else $error("outputs active right after reset");
  drive_only_a: assert property (!sda_out && !alert_out)
    else $error("open-drain pin driven high");
  hold_len_a: assert property ($fell(track_hold) |-> hold_cnt_reg == 8'h64 && !adc_power_up)
    else $error("hold phase not 100 cycles or no shutdown");
  power_hold_a: assert property (track_hold |-> adc_power_up)
    else $error("converting while powered down");
  start_rise_a: assert property ($rose(conversion_start_n) && !adc_power_up |-> ##[1:4] adc_power_up)
    else $error("start rise did not power up");
  start_fall_a: assert property ($fell(conversion_start_n) && !track_hold |-> ##[1:4] track_hold)
    else $error("start fall did not begin conversion");
  chan_stable_a: assert property (track_hold && $past(track_hold) |-> $stable(conv_channel))
    else $error("channel changed during conversion");
  hs_stop_a: assert property (scl_pin && $past(scl_pin) && $rose(sda_pin) |-> ##[1:5] !hs_mode)
    else $error("high-speed mode kept after stop");
  ack_edge_a: assert property ($changed(sda_oe) |-> !$past(scl_pin, 2))
    else $error("data line changed while clock high");
endmodule : adcc_convctl_properties
bind adcc_convctl adcc_convctl_properties u_props (
  .clk(clk), .resetn(resetn), .scl_pin(scl_pin), .sda_pin(sda_pin), .sda_out(sda_out),
  .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe), .conversion_start_n(conversion_start_n),
  .adc_power_up(adc_power_up), .track_hold(track_hold), .conv_channel(conv_channel), .hs_mode(hs_mode)
);
`default_nettype wire

// ### testbench/adcc_host.sv
// Bus master model of the two-wire serial port
`timescale 1ns/10ps
`default_nettype none
module adcc_host (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic scl_reg = 1'b1;
  logic sda_reg = 1'b1;
  assign scl = scl_reg;
  // Pull-up: high unless a party pulls low
  assign sda = sda_reg & ~sda_oe;
  // Also a repeated start; clock rises after data so no false stop
  task automatic start();
    sda_reg <= 1'b1;
    repeat (2) @(posedge clk);
    scl_reg <= 1'b1;
    repeat (4) @(posedge clk);
    sda_reg <= 1'b0;
    repeat (4) @(posedge clk);
    scl_reg <= 1'b0;
    @(posedge clk);
  endtask : start
  task automatic stop();
    sda_reg <= 1'b0;
    repeat (2) @(posedge clk);
    scl_reg <= 1'b1;
    repeat (4) @(posedge clk);
    sda_reg <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : stop
  // Four clocks low, four high: 160 ns bus period
  task automatic xbit(input logic bv, output logic r);
    sda_reg <= bv;
    repeat (3) @(posedge clk);
    scl_reg <= 1'b1;
    repeat (4) @(posedge clk);
    r = sda;
    scl_reg <= 1'b0;
    @(posedge clk);
  endtask : xbit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(last, r);
  endtask : rbyte
endmodule : adcc_host
`default_nettype wire

// ### testbench/adcc_convctl_bench.sv
// Self-checking bench of the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcc_convctl_bench;
  localparam logic [6:0] DEV = {adcc_pkg::ADDR_MSB, 4'h1};
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cs = 1'b0;
  logic        as_mid = 1'b0;
  logic [11:0] code = 12'h000;
  logic        scl, sda, sda_oe, alert_oe, adc_power_up, track_hold;
  logic        conv_channel, result_invalid, hs_mode, mid_oe, a;
  logic [3:0]  pcb;
  logic [7:0]  b;
  int          error_cnt = 0;
  int          n_checks = 0;
  // Select pin low; the midpoint input is raised for the last test only
  adcc_convctl u_dut (
    .clk(clk), .resetn(resetn), .scl_pin(scl), .sda_pin(sda), .sda_out(), .sda_oe(sda_oe),
    .alert_out(), .alert_oe(alert_oe), .conversion_start_n(cs), .address_select_pin(1'b0),
    .address_select_mid(as_mid), .adc_code(code), .adc_power_up(adc_power_up), .track_hold(track_hold),
    .conv_channel(conv_channel), .result_invalid(result_invalid), .hs_mode(hs_mode), .pointer_command_bits(pcb)
  );
  adcc_host u_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
    u_host.start();
    u_host.wbyte({DEV, 1'b0}, a);
    chk("wr_ack", a, 1'b1);
    u_host.wbyte(p, a);
    for (int i = n; i > 0; i--) u_host.wbyte(d[8*i-1 -: 8], a);
    u_host.stop();
  endtask : wr
  // Two units per read: a repeat for narrow registers, extra bytes for wide ones
  task automatic rd(input logic [7:0] p, input logic [15:0] exp, input int nb);
    wr(p, 16'h0000, 0);
    u_host.start();
    u_host.wbyte({DEV, 1'b1}, a);
    for (int i = 0; i < 2 * nb; i++) begin
      u_host.rbyte(i == 2 * nb - 1, b);
      chk("rd_byte", {8'h00, b}, {8'h00, (nb == 2 && i % 2 == 0) ? exp[15:8] : exp[7:0]});
    end
    u_host.stop();
  endtask : rd
  task automatic ara(input logic exp);
    u_host.start();
    u_host.wbyte({adcc_pkg::ARA_ADDR, 1'b1}, a);
    chk("ara_ack", a, exp);
    if (a) begin
      u_host.rbyte(1'b1, b);
      chk("ara_id", b, {DEV, 1'b0});
    end
    u_host.stop();
  endtask : ara
  // Bus stays idle, clock high, while the pin pulses
  task automatic conv(input int hi, input logic [11:0] c);
    code <= c;
    cs <= 1'b1;
    repeat (hi) @(posedge clk);
    cs <= 1'b0;
    repeat (8) @(posedge clk);
    mid_oe = alert_oe;
    chk("hold", track_hold, 1'b1);
    repeat (110) @(posedge clk);
    chk("shut", {track_hold, adc_power_up}, 2'b00);
    chk("invalid", result_invalid, hi < 50);
  endtask : conv
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    chk("idle_out", {alert_oe, sda_oe, hs_mode, track_hold, adc_power_up}, 16'h0000);
    wr(8'h02, 16'h0034, 1);
    wr(8'h05, 16'h0800, 2);
    wr(8'h06, 16'h0010, 2);
    rd(8'h05, 16'h0800, 2);
    conv(60, 12'h900);
    chk("alert_set", alert_oe, 1'b1);
    rd(8'h00, 16'h0900, 2);
    chk("cmd_bits", pcb, 4'h0);
    ara(1'b1);
    conv(10, 12'h100);
    chk("chan", conv_channel, 1'b1);
    rd(8'h00, 16'h5100, 2);
    wr(8'h02, 16'h0017, 1);
    chk("alert_clr", alert_oe, 1'b1);
    conv(60, 12'h900);
    chk("alert_hi", alert_oe, 1'b0);
    conv(60, 12'h7f0);
    chk("hys_clr", alert_oe, 1'b1);
    wr(8'h02, 16'h0010, 1);
    conv(60, 12'h900);
    chk("alert_off", alert_oe, 1'b0);
    ara(1'b0);
    wr(8'h02, 16'h0018, 1);
    conv(60, 12'h100);
    chk("busy", mid_oe ^ alert_oe, 1'b1);
    u_host.start();
    u_host.wbyte(8'h08, a);
    chk("hs_nack", {a, hs_mode}, 2'b01);
    u_host.start();
    u_host.wbyte({DEV, 1'b1}, a);
    chk("hs_ack", a, 1'b1);
    u_host.rbyte(1'b0, b);
    chk("cfg_1", b, 8'h18);
    u_host.rbyte(1'b1, b);
    chk("cfg_2", b, 8'h18);
    u_host.stop();
    chk("hs_exit", hs_mode, 1'b0);
    u_host.start();
    u_host.wbyte({adcc_pkg::ADDR_MSB, 4'h2, 1'b0}, a);
    chk("other_addr", a, 1'b0);
    u_host.stop();
    // Select is judged once per reset, so a floating pin needs a fresh reset
    as_mid <= 1'b1;
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    chk("rst_out", {alert_oe, sda_oe, hs_mode, track_hold, adc_power_up}, 16'h0000);
    u_host.start();
    u_host.wbyte({adcc_pkg::ADDR_MSB, 4'h3, 1'b0}, a);
    chk("float_addr", a, 1'b1);
    u_host.stop();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule : adcc_convctl_bench
`default_nettype wire
